// file: headset_model.sv
// headset_model.sv: behavioural 3.5-mm accessory driving the sense inputs
// assumes the bench sets plug, type and button levels right after a clock edge
`timescale 1ns/100ps
module headset_model
	import jack_ctrl_pkg::*;
(
	input  wire logic       clock_i, // bench clock
	input  wire logic       rst_i,   // synchronous reset
	input  wire ctrl_s      ctrl_i,  // block enables
	input  wire logic       plug_i,  // accessory in the jack
	input  wire logic [6:0] type_i,  // type the front end reports
	input  wire logic       press_i, // button held
	output sense_s          sense_o  // sense results
);
	logic [3:0] tick_reg;
	logic [2:0] conv_reg;
	logic       valid_reg;
	logic [6:0] code_reg;
	logic       done_reg;
	logic [9:0] value_reg;
	// one classification every 16 cycles while asked; codes off a pulse are inverted so
	// that a stale code never passes for a fresh one
	always_ff @(posedge clock_i)
	begin
		tick_reg  <= rst_i ? 4'h0 : tick_reg + 4'h1;
		valid_reg <= !rst_i && plug_i && ctrl_i.classify_run && tick_reg == 4'hf;
		code_reg  <= (tick_reg == 4'hf) ? type_i : ~type_i;
		conv_reg  <= rst_i ? 3'h0 : ctrl_i.adc_start ? 3'h4 : conv_reg - {2'h0, |conv_reg};
		done_reg  <= conv_reg == 3'h1;
		value_reg <= (conv_reg == 3'h1) ? 10'h2a5 : ~value_reg;
	end
	// contact levels follow the plug at once; type bit 2 means ground on ring2
	assign sense_o = {plug_i, code_reg, valid_reg, plug_i & type_i[2], plug_i & press_i,
		done_reg, value_reg};
endmodule // headset_model

// file: jack_ctrl.sv
// jack_ctrl.sv: detection, power, volume stepping and button logic of a headset interface
// assumes analog sense results arrive synchronous to clock_i and a classic wishbone master
//
// The Wishbone register port and the register offsets were decided locally.
`timescale 1ns/100ps

// Operation
// - repeat type classification after insertion until two results agree, then keep it
// - never classify again while the accessory stays inserted; shutdown or bias bypass still restarts classification
// - power only the blocks the detected accessory type needs
// - on removal switch every functional block off
// - each channel has its own 1 dB volume code and mute
// - link bit set applies the master setting to both channels
// - step actual volume one code every 3.25 ms toward the request
// - read-only flag shows actual volume has not yet reached request
// - slew disable bit makes volume changes immediate
// - detection result picks ring2 or sleeve as ground, closing only that switch
// - mic preamp gain selects 12 dB or 24 dB
// - bias selects 2.0 or 2.6 V; resistor 2.2, 2.6, 3.0 kohm or bypass
// - detection result routes ring2 or sleeve to the mic input
// - bias bypass disables detection, removal detection and mic amplifier
// - button comparator trips first, only then is the adc started
// - multi-button press and release reported, resistance and divider in 0x17; the key flag is set on press and never cleared on release
// - active-low power-on bit zero enters shutdown, stopping all detection
// - leaving shutdown restarts detection from the start
// - sleep bit keeps detection and single-button reporting, powers amplifiers down
// - auto mode with no accessory gives lowest power
// - removal raises interrupt and clears the jack present flag
// - detected type code held in 0x19 bits 6-0
// - end of slewing raises interrupt and slew done flag
// - single button event on press or release, status flag held while pressed
module jack_ctrl
	import jack_ctrl_pkg::*;
(
	input  wire logic        clock_i,  // 200 MHz
	input  wire logic        rst_i,    // synchronous, active high
	input  wire logic [31:0] wb_adr_i, // byte address
	input  wire logic [31:0] wb_dat_i, // write data
	input  wire logic [3:0]  wb_sel_i, // byte enables
	input  wire logic        wb_we_i,  // write
	input  wire logic        wb_cyc_i, // cycle
	input  wire logic        wb_stb_i, // strobe
	output logic      [31:0] wb_dat_o, // read data
	output logic             wb_ack_o, // acknowledge
	input  wire sense_s      sense_i,  // analog sense results
	output ctrl_s            ctrl_o,   // block enables and switches
	output logic             irq_o     // level, high while an enabled event is pending
);

	typedef enum logic [2:0] {DET_OFF, DET_WAIT, DET_FIRST, DET_SECOND, DET_DONE} det_e;
	typedef enum logic [1:0] {BTN_IDLE, BTN_CONV, BTN_HELD} btn_e;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// one step of a volume code toward its target, or a jump when stepping is off
	function automatic logic [5:0] step_toward(input logic [5:0] cur, input logic [5:0] tgt,
		input logic jump);
		if (jump || cur == tgt)
			return tgt;
		else if (cur < tgt)
			return cur + 6'h01;
		else
			return cur - 6'h01;
	endfunction

	function automatic logic [5:0] clamp_vol(input logic [5:0] v);
		return (v > VOL_MAX) ? VOL_MAX : v;
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	localparam logic [19:0] STEP_LAST = 20'(STEP_CYCLES - 1);

	logic [7:0]  mask_reg, mask_next;
	logic [7:0]  voll_reg, voll_next;
	logic [7:0]  volr_reg, volr_next;
	logic [7:0]  mic_reg, mic_next;
	logic [7:0]  power_reg, power_next;
	logic [7:0]  mode_reg, mode_next;
	logic [7:0]  pend_reg, pend_next;      // sticky events, same bit layout as mask
	logic        ack_reg, ack_next;
	logic [31:0] rdat_reg, rdat_next;
	det_e        det_reg, det_next;
	logic [6:0]  first_reg, first_next;
	logic [6:0]  type_reg, type_next;
	logic        jack_reg, jack_next;
	logic        gnd_r2_reg, gnd_r2_next;
	btn_e        btn_reg, btn_next;
	logic        press_reg, press_next;
	logic        key_reg, key_next;
	logic [9:0]  bdata_reg, bdata_next;
	logic [5:0]  actl_reg, actl_next;
	logic [5:0]  actr_reg, actr_next;
	logic [19:0] tick_reg, tick_next;
	logic        slewing_reg, slewing_next;
	ctrl_s       ctrl_reg, ctrl_next;

	logic       wr_go;
	logic       rd_go;
	logic [7:0] idx;
	logic       shutdown;
	logic       sleeping;
	logic       bypass;
	logic       det_alive;
	logic [5:0] tgt_l;
	logic [5:0] tgt_r;
	logic       done;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	// ack pulses one cycle after the request; ack_reg blocks a second take
	assign wr_go = wb_cyc_i && wb_stb_i && !ack_reg && wb_we_i && wb_sel_i[0];
	assign rd_go = wb_cyc_i && wb_stb_i && !ack_reg;
	assign idx   = wb_adr_i[9:2];

	assign shutdown  = !power_reg[BIT_PWRON];
	assign sleeping  = power_reg[BIT_SLEEP];
	assign bypass    = mic_reg[1:0] == BIAS_BYPASS;
	assign det_alive = !shutdown && !bypass;

	// linked channels both follow the left code as the master setting
	assign tgt_l = clamp_vol(voll_reg[5:0]);
	assign tgt_r = voll_reg[BIT_LINK] ? tgt_l : clamp_vol(volr_reg[5:0]);
	assign done  = actl_reg == tgt_l && actr_reg == tgt_r;

	// ----------------------------------------------------------------
	// software registers and read mux
	// ----------------------------------------------------------------
	always_comb
	begin
		mask_next  = mask_reg;
		voll_next  = voll_reg;
		volr_next  = volr_reg;
		mic_next   = mic_reg;
		power_next = power_reg;
		mode_next  = mode_reg;
		ack_next   = rd_go;
		rdat_next  = rdat_reg;
		if (wr_go)
		begin
			unique case (idx)
				IDX_MASK:  mask_next  = wb_dat_i[7:0];
				IDX_VOL_L: voll_next  = wb_dat_i[7:0];
				IDX_VOL_R: volr_next  = wb_dat_i[7:0];
				IDX_MIC:   mic_next   = wb_dat_i[7:0];
				IDX_POWER: power_next = {wb_dat_i[7:6], 6'h00};
				IDX_MODE:  mode_next  = wb_dat_i[7:0];
				default:   mask_next  = mask_reg;
			endcase
		end
		if (rd_go)
		begin
			rdat_next = 32'h0;
			unique case (idx)
				IDX_STATUS:  rdat_next[7:0] = {jack_reg, 1'b0, pend_reg[BIT_SLEWDN], 3'h0,
					press_reg, 1'b0};
				IDX_EVENT:   rdat_next[7:0] = {5'h0, key_reg, press_reg, 1'b0};
				IDX_MASK:    rdat_next[7:0] = mask_reg;
				IDX_VOL_L:   rdat_next[7:0] = voll_reg;
				IDX_VOL_R:   rdat_next[7:0] = volr_reg;
				IDX_MIC:     rdat_next[7:0] = mic_reg;
				IDX_BTNDATA: rdat_next[9:0] = bdata_reg;
				IDX_TYPE:    rdat_next[7:0] = {1'b0, type_reg};
				IDX_POWER:   rdat_next[7:0] = power_reg;
				IDX_MODE:    rdat_next[7:0] = {mode_reg[7:6], mode_reg[5], 2'h0, !done,
					mode_reg[1:0]};
				default:     rdat_next = 32'h0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// accessory detection
	// ----------------------------------------------------------------
	// classification only runs between insertion and agreement; a type change while
	// inserted is therefore invisible until removal, shutdown or bypass
	always_comb
	begin
		det_next    = det_reg;
		first_next  = first_reg;
		type_next   = type_reg;
		jack_next   = jack_reg;
		gnd_r2_next = gnd_r2_reg;
		if (!det_alive)
		begin
			det_next  = DET_OFF;
			jack_next = 1'b0;
			type_next = TYPE_NONE;
		end
		else
		begin
			unique case (det_reg)
				DET_OFF:   det_next = DET_WAIT;
				DET_WAIT:  if (sense_i.jack_sense)
					det_next = DET_FIRST;
				DET_FIRST: if (!sense_i.jack_sense)
					det_next = DET_WAIT;
				else if (sense_i.type_valid)
				begin
					first_next  = sense_i.type_code;
					gnd_r2_next = sense_i.ring2_ground;
					det_next    = DET_SECOND;
				end
				DET_SECOND: if (!sense_i.jack_sense)
					det_next = DET_WAIT;
				else if (sense_i.type_valid)
				begin
					first_next  = sense_i.type_code;
					gnd_r2_next = sense_i.ring2_ground;
					if (sense_i.type_code == first_reg)
					begin
						type_next = sense_i.type_code;
						jack_next = 1'b1;
						det_next  = DET_DONE;
					end
				end
				DET_DONE: if (!sense_i.jack_sense)
				begin
					jack_next = 1'b0;
					type_next = TYPE_NONE;
					det_next  = DET_WAIT;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// button detection
	// ----------------------------------------------------------------
	// the adc only runs after the comparator trips, keeping idle power low
	always_comb
	begin
		btn_next   = btn_reg;
		press_next = press_reg;
		key_next   = key_reg;
		bdata_next = bdata_reg;
		if (!jack_reg)
		begin
			btn_next   = BTN_IDLE;
			press_next = 1'b0;
		end
		else
		begin
			unique case (btn_reg)
				BTN_IDLE: if (sense_i.comp_trip)
				begin
					press_next = 1'b1;
					btn_next   = sleeping ? BTN_HELD : BTN_CONV;
				end
				BTN_CONV: if (sense_i.adc_done)
				begin
					bdata_next = sense_i.adc_value;
					key_next   = 1'b1;
					btn_next   = BTN_HELD;
				end
				BTN_HELD: if (!sense_i.comp_trip)
				begin
					press_next = 1'b0;
					btn_next   = BTN_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// volume soft stepping
	// ----------------------------------------------------------------
	always_comb
	begin
		actl_next    = actl_reg;
		actr_next    = actr_reg;
		tick_next    = tick_reg;
		slewing_next = !done;
		if (mode_reg[BIT_SLEWDIS])
		begin
			actl_next = tgt_l;
			actr_next = tgt_r;
			tick_next = 20'h0;
		end
		else if (done)
			tick_next = 20'h0;
		else if (tick_reg == STEP_LAST)
		begin
			tick_next = 20'h0;
			actl_next = step_toward(actl_reg, tgt_l, 1'b0);
			actr_next = step_toward(actr_reg, tgt_r, 1'b0);
		end
		else
			tick_next = tick_reg + 20'h1;
	end

	// ----------------------------------------------------------------
	// events, power and switches
	// ----------------------------------------------------------------
	always_comb
	begin
		logic auto_on;
		logic awake;
		auto_on   = mode_reg[1:0] == AUTO_ON;
		awake     = jack_reg && !sleeping && !shutdown;
		pend_next = pend_reg;
		// status reads clear pending events; a new event in that cycle wins
		// a write to the status index is ignored and must not clear anything
		if (rd_go && !wb_we_i && idx == IDX_STATUS)
			pend_next = 8'h00;
		if (jack_next && !jack_reg)
			pend_next[BIT_INS] = 1'b1;
		if (jack_reg && !jack_next)
			pend_next[BIT_REM] = 1'b1;
		if (press_next != press_reg)
			pend_next[BIT_BTN] = 1'b1;
		if (slewing_reg && done)
			pend_next[BIT_SLEWDN] = 1'b1;
		ctrl_next               = '0;
		ctrl_next.classify_run  = det_reg == DET_FIRST || det_reg == DET_SECOND;
		ctrl_next.mic_gain_hi   = mic_reg[2];
		ctrl_next.bias_hi       = mic_reg[3];
		ctrl_next.bias_res      = mic_reg[1:0];
		if (jack_reg)
		begin
			// type bit 0 marks a mic, bit 1 a right channel; without auto the host owns headphone power
			ctrl_next.bias_en       = type_reg[0];
			ctrl_next.comp_en       = type_reg[0] && !bypass;
			ctrl_next.adc_start     = btn_reg == BTN_IDLE && btn_next == BTN_CONV;
			ctrl_next.gnd_ring2_sw  = gnd_r2_reg;
			ctrl_next.gnd_sleeve_sw = !gnd_r2_reg;
			ctrl_next.mic_ring2_sw  = type_reg[0] && !gnd_r2_reg;
			ctrl_next.mic_sleeve_sw = type_reg[0] && gnd_r2_reg;
			ctrl_next.hp_left_en    = awake && (auto_on || mode_reg[7]);
			ctrl_next.hp_right_en   = awake && (auto_on ? type_reg[1] : mode_reg[6]);
			ctrl_next.mic_amp_en    = awake && type_reg[0] && !bypass;
		end
		// no accessory leaves every block off, which is the auto lowest-power state
		ctrl_next.vol_left   = actl_next;
		ctrl_next.vol_right  = actr_next;
		ctrl_next.mute_left  = voll_reg[BIT_MUTE];
		ctrl_next.mute_right = voll_reg[BIT_LINK] ? voll_reg[BIT_MUTE] : volr_reg[BIT_MUTE];
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			mask_reg    <= RST_MASK;
			voll_reg    <= RST_VOL;
			volr_reg    <= RST_VOL;
			mic_reg     <= RST_MIC;
			power_reg   <= RST_POWER;
			mode_reg    <= RST_MODE;
			pend_reg    <= 8'h00;
			ack_reg     <= 1'b0;
			rdat_reg    <= 32'h0;
			det_reg     <= DET_OFF;
			first_reg   <= TYPE_NONE;
			type_reg    <= TYPE_NONE;
			jack_reg    <= 1'b0;
			gnd_r2_reg  <= 1'b0;
			btn_reg     <= BTN_IDLE;
			press_reg   <= 1'b0;
			key_reg     <= 1'b0;
			bdata_reg   <= 10'h0;
			actl_reg    <= 6'h00;
			actr_reg    <= 6'h00;
			tick_reg    <= 20'h0;
			slewing_reg <= 1'b0;
			ctrl_reg    <= '0;
		end
		else
		begin
			mask_reg    <= mask_next;
			voll_reg    <= voll_next;
			volr_reg    <= volr_next;
			mic_reg     <= mic_next;
			power_reg   <= power_next;
			mode_reg    <= mode_next;
			pend_reg    <= pend_next;
			ack_reg     <= ack_next;
			rdat_reg    <= rdat_next;
			det_reg     <= det_next;
			first_reg   <= first_next;
			type_reg    <= type_next;
			jack_reg    <= jack_next;
			gnd_r2_reg  <= gnd_r2_next;
			btn_reg     <= btn_next;
			press_reg   <= press_next;
			key_reg     <= key_next;
			bdata_reg   <= bdata_next;
			actl_reg    <= actl_next;
			actr_reg    <= actr_next;
			tick_reg    <= tick_next;
			slewing_reg <= slewing_next;
			ctrl_reg    <= ctrl_next;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdat_reg;
	assign ctrl_o   = ctrl_reg;
	assign irq_o    = |(pend_reg & mask_reg);

endmodule // jack_ctrl

// file: jack_ctrl_checker.sv
// jack_ctrl_checker.sv: port-level assertions for the jack control block
// assumes it is bound into jack_ctrl and sees only that module's ports
`timescale 1ns/100ps
module jack_ctrl_checker
	import jack_ctrl_pkg::*;
(
	input wire logic   clock_i,  // clock
	input wire logic   rst_i,    // synchronous reset
	input wire logic   wb_cyc_i, // cycle
	input wire logic   wb_stb_i, // strobe
	input wire logic   wb_ack_o, // acknowledge
	input wire sense_s sense_i,  // sense results
	input wire ctrl_s  ctrl_o,   // enables and switches
	input wire logic   irq_o     // interrupt
);
	// ----
	// properties
	// ----
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	// a request not yet answered, and an accessory gone for three cycles
	sequence bus_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
	sequence jack_gone; !sense_i.jack_sense [*3]; endsequence
	AST_BUS_ACK: assert property (bus_req |=> wb_ack_o)
		else $error("bus request not answered next cycle");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	AST_GND_ONE: assert property (!(ctrl_o.gnd_ring2_sw && ctrl_o.gnd_sleeve_sw))
		else $error("both ground switches closed");
	AST_MIC_ONE: assert property (!(ctrl_o.mic_ring2_sw && ctrl_o.mic_sleeve_sw))
		else $error("both mic switches closed");
	AST_ADC_CAUSE: assert property (ctrl_o.adc_start |-> $past(sense_i.comp_trip))
		else $error("adc started without comparator trip");
	AST_ADC_PULSE: assert property (ctrl_o.adc_start |=> !ctrl_o.adc_start)
		else $error("adc start longer than one cycle");
	AST_REMOVE_OFF: assert property (jack_gone |->
		!ctrl_o.mic_amp_en && !ctrl_o.gnd_ring2_sw && !ctrl_o.gnd_sleeve_sw)
		else $error("blocks on with no accessory");
	AST_BYPASS_MIC: assert property ((ctrl_o.bias_res == BIAS_BYPASS) [*3] |->
		!ctrl_o.mic_amp_en)
		else $error("mic amplifier on in bias bypass");
	AST_IRQ_RESET: assert property ($fell(rst_i) |-> !irq_o)
		else $error("interrupt high after reset");
endmodule // jack_ctrl_checker

bind jack_ctrl jack_ctrl_checker chk_u (.clock_i(clock_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .sense_i(sense_i), .ctrl_o(ctrl_o),
	.irq_o(irq_o));

// file: jack_ctrl_pkg.sv
// jack_ctrl_pkg.sv: shared constants and carrier types for the headset jack control block
// assumes a classic wishbone slave with byte-wide registers, 10-bit at 0x17, on 32-bit words
package jack_ctrl_pkg;

	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_STATUS  = 8'h00; // jack present, slew done, single button
	localparam logic [7:0] IDX_EVENT   = 8'h01; // press level, multi-button
	localparam logic [7:0] IDX_MASK    = 8'h04; // event enables
	localparam logic [7:0] IDX_VOL_L   = 8'h07; // link bit 7, left volume code
	localparam logic [7:0] IDX_VOL_R   = 8'h08; // right volume code
	localparam logic [7:0] IDX_MIC     = 8'h09; // mic gain and bias setup
	localparam logic [7:0] IDX_BTNDATA = 8'h17; // measured button resistance
	localparam logic [7:0] IDX_TYPE    = 8'h19; // accessory type code
	localparam logic [7:0] IDX_POWER   = 8'h1d; // power-on and sleep
	localparam logic [7:0] IDX_MODE    = 8'h1e; // slew disable and auto mode

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int BIT_JACK    = 7;
	localparam int BIT_SLEWDN  = 5;
	localparam int BIT_BUTTON  = 1;
	localparam int BIT_KEY     = 2;
	localparam int BIT_LINK    = 7;
	localparam int BIT_MUTE    = 6;
	localparam int BIT_PWRON   = 7;
	localparam int BIT_SLEEP   = 6;
	localparam int BIT_SLEWDIS = 5;
	localparam int BIT_INS     = 7; // mask: insertion
	localparam int BIT_REM     = 6; // mask: removal
	localparam int BIT_BTN     = 1; // mask: button press or release

	// ----------------------------------------------------------------
	// reset values and codes
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_MASK  = 8'he2;
	localparam logic [7:0] RST_VOL   = 8'h40; // muted, code 0
	localparam logic [7:0] RST_MIC   = 8'h00;
	localparam logic [7:0] RST_POWER = 8'h80; // powered, awake
	localparam logic [7:0] RST_MODE  = 8'h01; // auto mode
	localparam logic [1:0] AUTO_ON   = 2'h1;
	localparam logic [1:0] BIAS_BYPASS = 2'h3;
	localparam logic [5:0] VOL_MAX   = 6'h30; // +6 dB; code 0 is -42 dB, 1 dB a code
	localparam logic [6:0] TYPE_NONE = 7'h00;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_KHZ      = 200000;
	localparam int STEP_US      = 3250; // 3.25 ms a volume step
	localparam int STEP_CYCLES  = STEP_US * (CLK_KHZ / 1000);

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       jack_sense;   // jack switch reports insertion
		logic [6:0] type_code;    // one classification result
		logic       type_valid;   // pulse: classification finished
		logic       ring2_ground; // result puts ground on contact three
		logic       comp_trip;    // button comparator below 1500 ohm
		logic       adc_done;     // pulse: impedance conversion done
		logic [9:0] adc_value;    // measured resistance, divider in top bits
	} sense_s;

	typedef struct packed {
		logic       classify_run;  // request classification passes
		logic       hp_left_en;
		logic       hp_right_en;
		logic       mic_amp_en;
		logic       mic_gain_hi;   // 24 dB when high, else 12 dB
		logic       bias_en;
		logic       bias_hi;       // 2.6 V when high, else 2.0 V
		logic [1:0] bias_res;      // 2.2k, 2.6k, 3.0k, bypass
		logic       gnd_ring2_sw;
		logic       gnd_sleeve_sw;
		logic       mic_ring2_sw;
		logic       mic_sleeve_sw;
		logic       comp_en;
		logic       adc_start;     // pulse
		logic [5:0] vol_left;
		logic [5:0] vol_right;
		logic       mute_left;
		logic       mute_right;
	} ctrl_s;

endpackage

// file: tb_top.sv
// tb_top.sv: self-checking bench for the jack control block
// assumes the headset model on the sense side and wishbone reaching the registers
`timescale 1ns/100ps
module tb_top;
	import jack_ctrl_pkg::*;
	logic        clock_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [31:0] wb_adr = 32'h0;
	logic [31:0] wb_dat = 32'h0;
	logic        wb_we = 1'b0;
	logic        wb_cyc = 1'b0;
	logic        wb_stb = 1'b0;
	logic [31:0] rd_dat;
	logic        ack;
	logic        irq;
	sense_s      sense;
	ctrl_s       ctrl;
	logic        plug = 1'b0;
	logic        press = 1'b0;
	logic [6:0]  acc_type = 7'h00;
	logic [31:0] q;
	logic [6:0]  path;
	int          err_count = 0;
	int          checks = 0;
	int          cycles = 0;
	logic [15:0] rst_tab [8] = '{16'h04e2, 16'h0740, 16'h0840, 16'h0900, 16'h1d80, 16'h1e01,
		16'h1900, 16'h3f00};
	// ----
	// design, accessory and clock
	// ----
	jack_ctrl dut_u (.clock_i(clock_i), .rst_i(rst_i), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat),
		.wb_sel_i(4'h1), .wb_we_i(wb_we), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_dat_o(rd_dat), .wb_ack_o(ack), .sense_i(sense), .ctrl_o(ctrl), .irq_o(irq));
	headset_model acc_u (.clock_i(clock_i), .rst_i(rst_i), .ctrl_i(ctrl), .plug_i(plug),
		.type_i(acc_type), .press_i(press), .sense_o(sense));
	assign path = {ctrl.hp_left_en, ctrl.hp_right_en, ctrl.mic_amp_en, ctrl.gnd_ring2_sw,
		ctrl.gnd_sleeve_sw, ctrl.mic_ring2_sw, ctrl.mic_sleeve_sw};
	initial
	begin
		forever #2.5 clock_i = ~clock_i;
	end
	// a hang ends the run as a failure
	always @(posedge clock_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_count++;
			results();
		end
	end
	// ----
	// tasks
	// ----
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_port(input logic [7:0] got, input logic [7:0] exp);
		cmp({24'h0, got}, {24'h0, exp});
	endtask
	// classic cycle: held until ack is sampled, released at that edge
	task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] d);
		@(posedge clock_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we  <= we;
		wb_adr <= {22'h0, idx, 2'h0};
		wb_dat <= {24'h0, d};
		@(posedge clock_i);
		while (ack !== 1'b1)
			@(posedge clock_i);
		q = rd_dat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d);
	endtask
	task automatic rd(input logic [7:0] idx, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, idx, 8'h00);
		cmp(q & m, e);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clock_i);
	endtask
	// two edges first, so the awaited pulse carries the new code
	task automatic classify(input logic [6:0] t);
		acc_type <= t;
		repeat (2) @(posedge clock_i);
		while (sense.type_valid !== 1'b1)
			@(posedge clock_i);
	endtask
	task automatic results();
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ----
	// scenarios
	// ----
	initial
	begin
		wt(12);
		rst_i <= 1'b0;
		foreach (rst_tab[i])
			rd(rst_tab[i][15:8], 32'hffffffff, {24'h0, rst_tab[i][7:0]});
		wr(8'h19, 8'h55);
		rd(8'h19, 32'hff, 32'h0);
		// insertion: a disagreeing pair must not settle the type
		plug <= 1'b1;
		classify(7'h05);
		classify(7'h07);
		wt(3);
		rd(8'h00, 32'h80, 32'h00);
		classify(7'h07);
		wt(3);
		cmp_port({7'h0, irq}, 8'h01);
		rd(8'h00, 32'h80, 32'h80);
		rd(8'h19, 32'h7f, 32'h07);
		// a new type while inserted must not start classification again
		acc_type <= 7'h06;
		wt(40);
		cmp_port({7'h0, ctrl.classify_run}, 8'h00);
		rd(8'h19, 32'h7f, 32'h07);
		cmp_port({1'b0, path}, 8'h79);
		cmp_port({7'h0, irq}, 8'h00);
		// button: comparator, then the conversion
		press <= 1'b1;
		wt(20);
		rd(8'h00, 32'h02, 32'h02);
		rd(8'h01, 32'h06, 32'h06);
		rd(8'h17, 32'h3ff, 32'h2a5);
		press <= 1'b0;
		wt(4);
		rd(8'h01, 32'h02, 32'h00);
		// volume with stepping off, clamp, link, then stepping back on
		wr(8'h1e, 8'h21);
		wr(8'h08, 8'h03);
		wr(8'h07, 8'h0c);
		wt(4);
		cmp_port({ctrl.vol_left, ctrl.mute_left, ctrl.mute_right}, 8'h30);
		cmp_port({2'h0, ctrl.vol_right}, 8'h03);
		wr(8'h07, 8'h3f);
		wt(4);
		cmp_port({2'h0, ctrl.vol_left}, {2'h0, VOL_MAX});
		wr(8'h07, 8'h85);
		wt(4);
		cmp_port({2'h0, ctrl.vol_right}, 8'h05);
		rd(8'h00, 32'h20, 32'h20);
		rd(8'h1e, 32'h04, 32'h00);
		wr(8'h1e, 8'h01);
		wr(8'h07, 8'h8d);
		wt(100);
		cmp_port({2'h0, ctrl.vol_left}, 8'h05);
		rd(8'h1e, 32'h04, 32'h04);
		// mic setup, then bias bypass and recovery
		wr(8'h09, 8'h0e);
		wt(3);
		cmp_port({4'h0, ctrl.mic_gain_hi, ctrl.bias_hi, ctrl.bias_res}, 8'h0e);
		wr(8'h09, 8'h03);
		wt(3);
		cmp_port({7'h0, ctrl.mic_amp_en}, 8'h00);
		rd(8'h00, 32'h80, 32'h00);
		wr(8'h09, 8'h00);
		classify(7'h07);
		classify(7'h07);
		// sleep keeps detection, drops amplifiers
		wr(8'h1d, 8'hc0);
		wt(3);
		cmp_port({5'h0, path[6:4]}, 8'h00);
		rd(8'h00, 32'h80, 32'h80);
		wr(8'h1d, 8'h80);
		// shutdown and restart of detection
		wr(8'h1d, 8'h00);
		wt(3);
		rd(8'h00, 32'h80, 32'h00);
		wr(8'h1d, 8'h80);
		classify(7'h07);
		classify(7'h07);
		wt(3);
		rd(8'h00, 32'h80, 32'h80);
		// removal and the host's answer to it
		plug <= 1'b0;
		wt(4);
		cmp_port({7'h0, irq}, 8'h01);
		rd(8'h00, 32'h80, 32'h00);
		rd(8'h01, 32'h02, 32'h0);
		rd(8'h02, 32'hff, 32'h0);
		wr(8'h1d, 8'hc0);
		wt(3);
		cmp_port({1'b0, path}, 8'h00);
		results();
	end
endmodule // tb_top
